//--- rtl/pipe_timing_calc.sv
// cycle cost calculator for a four-stage pipeline timing model
// assumes one descriptor per valid cycle, inputs synchronous to clock,
// and no wait states on the external bus
`include "pipe_timing_defines.svh"

// What this block does
// - two general operands both in memory add 2 address cycles, else 0.
// - each operand adds 3 memory relative, 8 external, 2 scaled, else 0.
// - float instructions add 3 address cycles plus 2 per 64-bit mem operand.
// - transfer is id and opcode if no operand, else the last 32 bits only.
// - after completion the cpu handles the done signal then reads results.
// - completion time picks index 0 for 32-bit and 1 for 64-bit operands.
// - break 0 stops the address unit but it resumes at once.
// - a positive break K makes the address unit wait K cycles.
// - a negative break K lets the next instruction start |K| cycles early.
// - draining pending writes costs 6 to 7 cycles plus 2 for a second.
// - locked bit clear or set adds 3 cycles after the drain.
// - each conditional branch falls in one of four outcome classes.
// - without a break, address time is hidden up to the prior work.
// - after break K the exposed address time is au plus K, floored at 0.
// - float overhead is transfer plus completion plus slave time, else 0.
// - total is exposed address plus execution plus float plus drain plus delays.
module pipe_timing_calc
   import pipe_timing_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_instr_valid,
   input wire instr_desc_s i_instr,
   output logic o_cost_valid,
   output cost_s o_cost
);

   cost_s cost_q;
   cost_s cost_d;
   logic cost_valid_q;
   cyc_t prev_eu_q;
   cyc_t prev_flt_q;
   logic prev_brk_q;
   brk_t prev_k_q;

   // address unit extras for the operand pair and per operand
   wire both_mem = i_instr.two_gen_ops & i_instr.op1_mem & i_instr.op2_mem;
   wire cyc_t tx_w = both_mem ? `TX_BOTH_MEM : `TY_OTHER;
   cyc_t ty_w [2];
   addr_mode_e mode_w [2];
   assign mode_w[0] = i_instr.mode1;
   assign mode_w[1] = i_instr.mode2;

   // same mode decode for both operands
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_ty
         assign ty_w[g] =
            (mode_w[g] == MODE_MEM_REL) ? `TY_MEM_REL :
            (mode_w[g] == MODE_EXTERNAL) ? `TY_EXTERNAL :
            (mode_w[g] == MODE_SCALED) ? `TY_SCALED :
            `TY_OTHER;
      end
   endgenerate

   wire cyc_t addr_extra_w = tx_w + ty_w[0] + ty_w[1];

   // float address extras only apply to float instructions
   wire cyc_t n64_w = {10'h000, i_instr.mem64_ops};
   wire cyc_t fp_au_w = i_instr.is_fp ?
      `FP_AU_BASE + `FP_AU_PER64 * n64_w : 12'h000;

   wire cyc_t au_w = i_instr.base_au_time + addr_extra_w + fp_au_w;

   // transfer phase: earlier words already sit in execution time
   wire cyc_t xfer_w = i_instr.sends_operand ?
      i_instr.last_xfer_time : i_instr.idop_xfer_time;

   // completion: done handling first, then the result read by size
   wire cyc_t rd_w = i_instr.dbl_size ?
      `CPL_RD_DBL : `CPL_RD_SGL;
   wire cyc_t cpl_w = `CPL_DONE +
      (i_instr.has_result ? rd_w : 12'h000);

   // float overhead forced to zero on integer work
   wire cyc_t flt_raw_w = xfer_w + cpl_w + i_instr.slave_exec_time;
   wire cyc_t flt_w = i_instr.is_fp ? flt_raw_w : 12'h000;

   // hiding against the previous instruction
   wire cyc_t hide_w = prev_eu_q + prev_flt_q;
   wire cyc_t excess_w = au_w - prev_eu_q;
   wire cyc_t nobrk_w = (au_w <= hide_w) ?
      12'h000 : excess_w;

   // break path in signed arithmetic; floor at zero
   wire logic signed [13:0] brk_sum_w =
      $signed({2'b00, au_w}) + 14'(prev_k_q);
   wire cyc_t brk_exp_w = (brk_sum_w <= 14'sh0000) ?
      12'h000 : brk_sum_w[11:0];
   wire cyc_t exposed_w = prev_brk_q ? brk_exp_w : nobrk_w;

   // write drain uses the worst case of the range
   wire cyc_t drain_one_w = i_instr.drain ?
      `DRAIN_FIRST_MAX : 12'h000;
   wire cyc_t drain_two_w = (i_instr.drain & i_instr.second_wr) ?
      `DRAIN_SECOND : 12'h000;
   wire locked_w = i_instr.locked_bit_clear | i_instr.locked_bit_set;
   wire cyc_t rmw_w = (i_instr.drain & locked_w) ?
      `RMW_EXTRA : 12'h000;
   wire cyc_t drain_w = drain_one_w + drain_two_w + rmw_w;

   // branch outcome class
   wire mispred_w = i_instr.is_cond_br &
      (i_instr.br_taken != i_instr.br_pred_taken);
   wire branch_class_e cls_w =
      i_instr.br_taken ?
         (mispred_w ? TAKEN_PREDICTED_WRONG : TAKEN_PREDICTED_RIGHT) :
         (mispred_w ? NOT_TAKEN_PREDICTED_WRONG :
          NOT_TAKEN_PREDICTED_RIGHT);

   // a wrong guess flushes, so it carries a break to the next one
   wire cur_brk_w = i_instr.brk | mispred_w;
   wire brk_t cur_k_w = mispred_w ? `BR_MISS_BREAK : i_instr.brk_k;

   // total cost; dependency and storage delays arrive from outside
   wire cyc_t total_w = exposed_w + i_instr.exec_unit_time + flt_w +
      drain_w + i_instr.dep_delay + i_instr.stor_delay;

   // gather the result word, all whole cycles
   always_comb
   begin
      cost_d = cost_q;
      if (i_instr_valid)
      begin
         cost_d.addr_extra_time = addr_extra_w;
         cost_d.fp_addr_extra_time = fp_au_w;
         cost_d.au_time = au_w;
         cost_d.exposed_au_time = exposed_w;
         cost_d.xfer_time = i_instr.is_fp ? xfer_w : 12'h000;
         cost_d.cpl_time = i_instr.is_fp ? cpl_w : 12'h000;
         cost_d.float_overhead_time = flt_w;
         cost_d.drain_time = drain_w;
         cost_d.total_time = total_w;
         cost_d.br_class = cls_w;
      end
   end

   // output registers; data holds between instructions
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         cost_q <= '0;
         cost_valid_q <= 1'b0;
      end
      else
      begin
         cost_q <= cost_d;
         cost_valid_q <= i_instr_valid;
      end
   end

   // history of the previous instruction, cleared by reset
   always_ff @(posedge i_core_clk)
   begin
      if (i_srst)
      begin
         prev_eu_q <= 12'h000;
         prev_flt_q <= 12'h000;
         prev_brk_q <= 1'b0;
         prev_k_q <= 8'sh00;
      end
      else if (i_instr_valid)
      begin
         prev_eu_q <= i_instr.exec_unit_time;
         prev_flt_q <= flt_w;
         prev_brk_q <= cur_brk_w;
         prev_k_q <= cur_k_w;
      end
   end

   assign o_cost = cost_q;
   assign o_cost_valid = cost_valid_q;

   // checks on the model
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (i_srst);

   sequence s_issue;
      i_instr_valid ##1 o_cost_valid;
   endsequence

   sequence s_plain_modes;
      i_instr.mode1 == MODE_OTHER && i_instr.mode2 == MODE_OTHER;
   endsequence

   AST_TX_BOTH_MEM:
   assert property (i_instr_valid && both_mem ##0 s_plain_modes |=>
      o_cost.addr_extra_time == 12'h002)
   else $error("both-memory extra is not 2");

   AST_TX_NONE:
   assert property (i_instr_valid && !both_mem ##0 s_plain_modes |=>
      o_cost.addr_extra_time == 12'h000)
   else $error("extra cycles without both-memory operands");

   AST_TY_MODES:
   assert property (i_instr_valid && !both_mem &&
      i_instr.mode1 == MODE_MEM_REL && i_instr.mode2 == MODE_EXTERNAL
      |=> o_cost.addr_extra_time == 12'h00B)
   else $error("mode extras wrong");

   AST_FP_AU:
   assert property (i_instr_valid && i_instr.is_fp |=>
      o_cost.fp_addr_extra_time ==
      12'h003 + 12'h002 * {10'h000, $past(i_instr.mem64_ops)})
   else $error("float address extra wrong");

   AST_XFER_IDOP:
   assert property (i_instr_valid && i_instr.is_fp &&
      !i_instr.sends_operand |=>
      o_cost.xfer_time == $past(i_instr.idop_xfer_time))
   else $error("transfer is not id and opcode");

   AST_CPL_DBL:
   assert property (i_instr_valid && i_instr.is_fp &&
      i_instr.dbl_size && i_instr.has_result |=>
      o_cost.cpl_time == 12'h006)
   else $error("double completion wrong");

   AST_CPL_SGL_NORES:
   assert property (i_instr_valid && i_instr.is_fp &&
      !i_instr.has_result |=> o_cost.cpl_time == 12'h002)
   else $error("completion without result wrong");

   AST_FLT_ZERO:
   assert property (i_instr_valid && !i_instr.is_fp |=>
      o_cost.float_overhead_time == 12'h000)
   else $error("integer instruction has float overhead");

   AST_HIDDEN:
   assert property (i_instr_valid && !prev_brk_q && au_w <= hide_w
      |=> o_cost.exposed_au_time == 12'h000)
   else $error("address time not hidden");

   AST_BRK_POS:
   assert property (i_instr_valid && cur_brk_w && cur_k_w > 0
      ##1 i_instr_valid |=>
      o_cost.exposed_au_time == $past(au_w) + 12'($past(cur_k_w, 2)))
   else $error("positive break not added");

   AST_BRK_ZERO:
   assert property (i_instr_valid && prev_brk_q && prev_k_q == 0
      |=> o_cost.exposed_au_time == $past(au_w))
   else $error("break 0 should expose whole address time");

   AST_BRK_FLOOR:
   assert property (i_instr_valid && prev_brk_q && brk_sum_w < 0
      |=> o_cost.exposed_au_time == 12'h000)
   else $error("negative break not floored");

   AST_DRAIN_ONE:
   assert property (i_instr_valid && i_instr.drain &&
      !i_instr.second_wr && !locked_w |=> o_cost.drain_time == 12'h007)
   else $error("single drain wrong");

   AST_RMW:
   assert property (i_instr_valid && i_instr.drain &&
      i_instr.second_wr && locked_w |=> o_cost.drain_time == 12'h00C)
   else $error("locked rmw drain wrong");

   AST_BR_WRONG:
   assert property (s_issue ##0 $past(i_instr.is_cond_br &&
      i_instr.br_taken && !i_instr.br_pred_taken) |->
      o_cost.br_class == TAKEN_PREDICTED_WRONG)
   else $error("branch class wrong");

   AST_TOTAL:
   assert property (s_issue |-> o_cost.total_time ==
      o_cost.exposed_au_time + o_cost.float_overhead_time +
      o_cost.drain_time + $past(i_instr.exec_unit_time) +
      $past(i_instr.dep_delay) + $past(i_instr.stor_delay))
   else $error("total does not add up");

   AST_HOLD:
   assert property (!i_instr_valid |=> $stable(o_cost))
   else $error("cost changed without an instruction");

   AST_ANSWER:
   assert property (i_instr_valid |=> o_cost_valid)
   else $error("no cost one cycle after a descriptor");

   AST_NO_ANSWER:
   assert property (!i_instr_valid |=> !o_cost_valid)
   else $error("cost valid without a descriptor");

   AST_TY_EXT_SCALED:
   assert property (i_instr_valid && !both_mem &&
      i_instr.mode1 == MODE_EXTERNAL && i_instr.mode2 == MODE_SCALED
      |=> o_cost.addr_extra_time == 12'h00A)
   else $error("external plus scaled extras wrong");

   AST_FP_AU_ZERO:
   assert property (i_instr_valid && !i_instr.is_fp |=>
      o_cost.fp_addr_extra_time == 12'h000)
   else $error("integer instruction has float address extra");

   AST_XFER_LAST:
   assert property (i_instr_valid && i_instr.is_fp &&
      i_instr.sends_operand |=>
      o_cost.xfer_time == $past(i_instr.last_xfer_time))
   else $error("transfer is not the last operand word");

   AST_CPL_SGL_RES:
   assert property (i_instr_valid && i_instr.is_fp &&
      !i_instr.dbl_size && i_instr.has_result |=>
      o_cost.cpl_time == 12'h004)
   else $error("single completion wrong");

   AST_FLT_SUM:
   assert property (i_instr_valid && i_instr.is_fp |=>
      o_cost.float_overhead_time == o_cost.xfer_time +
      o_cost.cpl_time + $past(i_instr.slave_exec_time))
   else $error("float overhead does not add up");

   AST_DRAIN_TWO:
   assert property (i_instr_valid && i_instr.drain &&
      i_instr.second_wr && !locked_w |=> o_cost.drain_time == 12'h009)
   else $error("second drain wrong");

   AST_NO_DRAIN:
   assert property (i_instr_valid && !i_instr.drain |=>
      o_cost.drain_time == 12'h000)
   else $error("drain time without a drain");

   AST_EXCESS:
   assert property (i_instr_valid && !prev_brk_q && au_w > hide_w |=>
      o_cost.exposed_au_time == $past(au_w) - $past(prev_eu_q))
   else $error("exposed excess wrong");

   AST_BRK_NEG:
   assert property (i_instr_valid && prev_brk_q && prev_k_q < 0 &&
      brk_sum_w > 0 |=>
      o_cost.exposed_au_time == $past(au_w) + 12'($past(prev_k_q)))
   else $error("negative break not subtracted");

   AST_MISS_BREAK:
   assert property (i_instr_valid && mispred_w |=>
      prev_brk_q && prev_k_q == 8'sh02)
   else $error("mispredicted branch left no break");

   AST_BR_NT_WRONG:
   assert property (s_issue ##0 $past(i_instr.is_cond_br &&
      !i_instr.br_taken && i_instr.br_pred_taken) |->
      o_cost.br_class == NOT_TAKEN_PREDICTED_WRONG)
   else $error("not-taken branch class wrong");

endmodule // pipe_timing_calc

//--- rtl/pipe_timing_defines.svh
// cycle figures for the pipeline timing model
// assumes one core clock; every figure is in whole core cycles
`ifndef PIPE_TIMING_DEFINES_SVH
`define PIPE_TIMING_DEFINES_SVH

// address unit extras
`define TX_BOTH_MEM 12'h002
`define TY_MEM_REL 12'h003
`define TY_EXTERNAL 12'h008
`define TY_SCALED 12'h002
`define TY_OTHER 12'h000

// floating-point address unit extras
`define FP_AU_BASE 12'h003
`define FP_AU_PER64 12'h002

// completion phase, index 0 single, index 1 double
`define CPL_DONE 12'h002
`define CPL_RD_SGL 12'h002
`define CPL_RD_DBL 12'h004

// pending write drain and locked rmw
`define DRAIN_FIRST_MIN 12'h006
`define DRAIN_FIRST_MAX 12'h007
`define DRAIN_SECOND 12'h002
`define RMW_EXTRA 12'h003

// break forced onto a mispredicted conditional branch
`define BR_MISS_BREAK 8'sh02

`endif

//--- rtl/pipe_timing_pkg.sv
// types shared by the pipeline timing model
// assumes the defines header holds all figures
package pipe_timing_pkg;

   typedef logic [11:0] cyc_t;
   typedef logic signed [7:0] brk_t;

   typedef enum logic [1:0]
   {
      MODE_OTHER,
      MODE_MEM_REL,
      MODE_EXTERNAL,
      MODE_SCALED
   } addr_mode_e;

   typedef enum logic [1:0]
   {
      TAKEN_PREDICTED_RIGHT,
      TAKEN_PREDICTED_WRONG,
      NOT_TAKEN_PREDICTED_RIGHT,
      NOT_TAKEN_PREDICTED_WRONG
   } branch_class_e;

   // one instruction as seen by the timing model
   typedef struct packed {
      logic two_gen_ops;
      logic op1_mem;
      logic op2_mem;
      addr_mode_e mode1;
      addr_mode_e mode2;
      cyc_t base_au_time;
      cyc_t exec_unit_time;
      logic is_fp;
      logic [1:0] mem64_ops;
      logic sends_operand;
      cyc_t idop_xfer_time;
      cyc_t last_xfer_time;
      logic dbl_size;
      logic has_result;
      cyc_t slave_exec_time;
      logic brk;
      brk_t brk_k;
      logic drain;
      logic second_wr;
      logic locked_bit_clear;
      logic locked_bit_set;
      logic is_cond_br;
      logic br_taken;
      logic br_pred_taken;
      cyc_t dep_delay;
      cyc_t stor_delay;
   } instr_desc_s;

   // costs reported for one instruction
   typedef struct packed {
      cyc_t addr_extra_time;
      cyc_t fp_addr_extra_time;
      cyc_t au_time;
      cyc_t exposed_au_time;
      cyc_t xfer_time;
      cyc_t cpl_time;
      cyc_t float_overhead_time;
      cyc_t drain_time;
      cyc_t total_time;
      branch_class_e br_class;
   } cost_s;

endpackage

//--- tb/fp_slave_model.sv
// behavioural floating-point slave: offers an execution time and result flag
// assumes the bench reads these outputs away from the rising edge
module fp_slave_model
   import pipe_timing_pkg::*;
(
   input wire logic i_core_clk,
   output cyc_t o_exec_time,
   output logic o_has_result
);
   timeunit 1ns;
   timeprecision 1ns;

   initial
   begin
      o_exec_time = 12'h000;
      o_has_result = 1'b0;
   end

   // fresh offer each rising edge; slow answers mixed in, as a real slave has them
   always @(posedge i_core_clk)
   begin
      if ($urandom_range(3) == 0)
         o_exec_time <= cyc_t'($urandom_range(60, 20)); // slow
      else
         o_exec_time <= cyc_t'($urandom_range(3)); // prompt
      o_has_result <= 1'($urandom_range(1));
   end
endmodule // fp_slave_model

//--- tb/tb_pipeline_timing_model.sv
// self-checking bench for the pipeline timing calculator
// assumes one core clock; expected costs are predicted when driven
`define CHK(nm, ex, gt) \
   begin \
      n_compared++; \
      if ((gt) !== (ex)) \
      begin \
         err_count++; \
         $display("[FAIL] %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module tb_pipeline_timing_model;
   timeunit 1ns;
   timeprecision 1ns;
   import pipe_timing_pkg::*;
   logic i_core_clk;
   logic i_srst;
   logic i_instr_valid;
   instr_desc_s i_instr;
   logic o_cost_valid;
   cost_s o_cost;
   cyc_t slv_time;
   logic slv_res;
   int err_count;
   int n_compared;
   int h_eu, h_flt, h_k;
   logic h_brk;
   cost_s exp_q[$];
   cost_s e;

   pipe_timing_calc i_pipe_timing_calc (.i_core_clk(i_core_clk),
      .i_srst(i_srst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
      .o_cost_valid(o_cost_valid), .o_cost(o_cost));
   fp_slave_model i_fp_slave_model (.i_core_clk(i_core_clk),
      .o_exec_time(slv_time), .o_has_result(slv_res));

   initial
   begin
      i_core_clk = 1'b0;
      forever #25 i_core_clk = ~i_core_clk;
   end

   function automatic int ty(addr_mode_e m);
      case (m)
         MODE_MEM_REL: return 3;
         MODE_EXTERNAL: return 8;
         MODE_SCALED: return 2;
         default: return 0;
      endcase
   endfunction

   // expected cost from the descriptor and the last sent instruction
   task automatic predict(input instr_desc_s d);
      cost_s c;
      int ad, fp, au, xf, cp, fl, dr, ex;
      logic miss;
      c = '0;
      ad = ((d.two_gen_ops && d.op1_mem && d.op2_mem) ? 2 : 0)
         + ty(d.mode1) + ty(d.mode2);
      fp = d.is_fp ? 3 + 2 * d.mem64_ops : 0;
      xf = d.is_fp ? (d.sends_operand ? d.last_xfer_time
         : d.idop_xfer_time) : 0;
      cp = d.is_fp ? 2 + (d.has_result ? (d.dbl_size ? 4 : 2) : 0)
         : 0;
      fl = d.is_fp ? xf + cp + d.slave_exec_time : 0;
      dr = d.drain ? 7 + (d.second_wr ? 2 : 0) + ((d.locked_bit_clear
         || d.locked_bit_set) ? 3 : 0) : 0;
      au = d.base_au_time + ad + fp;
      if (h_brk)
         ex = (au + h_k > 0) ? au + h_k : 0;
      else
         ex = (au <= h_eu + h_flt) ? 0 : au - h_eu;
      miss = d.is_cond_br && (d.br_taken != d.br_pred_taken);
      c.br_class = d.br_taken ? (miss ? TAKEN_PREDICTED_WRONG
         : TAKEN_PREDICTED_RIGHT) : (miss ? NOT_TAKEN_PREDICTED_WRONG
         : NOT_TAKEN_PREDICTED_RIGHT);
      c.addr_extra_time = cyc_t'(ad);
      c.fp_addr_extra_time = cyc_t'(fp);
      c.au_time = cyc_t'(au);
      c.exposed_au_time = cyc_t'(ex);
      c.xfer_time = cyc_t'(xf);
      c.cpl_time = cyc_t'(cp);
      c.float_overhead_time = cyc_t'(fl);
      c.drain_time = cyc_t'(dr);
      c.total_time = cyc_t'(ex + d.exec_unit_time + fl + dr + d.dep_delay
         + d.stor_delay);
      h_eu = d.exec_unit_time;
      h_flt = fl;
      h_brk = d.brk || (d.is_cond_br && miss);
      h_k = (d.is_cond_br && miss) ? 2 : d.brk_k;
      exp_q.push_back(c);
   endtask

   // small fields keep every sum far from the 12-bit wrap
   function automatic instr_desc_s rnd();
      logic [127:0] raw;
      instr_desc_s d;
      raw = {$urandom, $urandom, $urandom, $urandom};
      d = instr_desc_s'(raw[$bits(instr_desc_s)-1:0]);
      d.base_au_time = cyc_t'($urandom_range(31));
      d.exec_unit_time = cyc_t'($urandom_range(31));
      d.idop_xfer_time = cyc_t'($urandom_range(9));
      d.last_xfer_time = cyc_t'($urandom_range(9));
      d.dep_delay = cyc_t'($urandom_range(5));
      d.stor_delay = cyc_t'($urandom_range(5));
      d.brk_k = brk_t'(int'($urandom_range(40)) - 20);
      d.slave_exec_time = slv_time;
      d.has_result = slv_res;
      return d;
   endfunction

   // called at a falling edge; valid stays up for back-to-back sends
   task automatic send(input instr_desc_s d);
      i_instr_valid = 1'b1;
      i_instr = d;
      predict(d);
      @(negedge i_core_clk);
   endtask

   task automatic idle(input int n);
      i_instr_valid = 1'b0;
      repeat (n) @(negedge i_core_clk);
   endtask

   task automatic do_reset(input int n);
      i_srst = 1'b1;
      repeat (n)
      begin
         @(negedge i_core_clk);
         `CHK("valid_in_reset", 1'b0, o_cost_valid)
         `CHK("cost_in_reset", cost_s'(0), o_cost)
      end
      i_srst = 1'b0;
      h_eu = 0;
      h_flt = 0;
      h_brk = 1'b0;
   endtask

   task automatic final_report();
      `CHK("left_over", 0, exp_q.size())
      $display("compared %0d errors %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // result watcher: each answer pairs with the oldest prediction
   always @(negedge i_core_clk)
   begin
      if (o_cost_valid === 1'b1)
      begin
         if (exp_q.size() == 0)
            `CHK("spurious_valid", 1'b0, o_cost_valid)
         else
         begin
            e = exp_q.pop_front();
            `CHK("addr_extra", e.addr_extra_time, o_cost.addr_extra_time)
            `CHK("fp_extra", e.fp_addr_extra_time, o_cost.fp_addr_extra_time)
            `CHK("au", e.au_time, o_cost.au_time)
            `CHK("xfer", e.xfer_time, o_cost.xfer_time)
            `CHK("cpl", e.cpl_time, o_cost.cpl_time)
            `CHK("flt", e.float_overhead_time, o_cost.float_overhead_time)
            `CHK("drain", e.drain_time, o_cost.drain_time)
            `CHK("exposed", e.exposed_au_time, o_cost.exposed_au_time)
            `CHK("total", e.total_time, o_cost.total_time)
            `CHK("br_class", e.br_class, o_cost.br_class)
         end
      end
   end

   // watchdog sized well past the roughly 1450 cycles the tests take on average
   initial
   begin
      #(6000 * 50);
      err_count++;
      final_report();
   end

   // main sequence: mode table, random stream, reset, random stream
   initial
   begin
      instr_desc_s d;
      i_instr_valid = 1'b0;
      i_instr = '0;
      err_count = 0;
      n_compared = 0;
      void'($urandom(3));
      do_reset(8);
      for (int s = 0; s < 128; s++)
      begin
         d = rnd();
         d.mode1 = addr_mode_e'(s[1:0]);
         d.mode2 = addr_mode_e'(s[3:2]);
         {d.two_gen_ops, d.op1_mem, d.op2_mem} = s[6:4];
         send(d);
      end
      for (int r = 0; r < 2; r++)
      begin
         for (int i = 0; i < 400; i++)
         begin
            send(rnd());
            if ($urandom_range(3) == 0)
               idle($urandom_range(3) + 1);
         end
         idle(3);
         do_reset(2);
      end
      final_report();
   end
endmodule // tb_pipeline_timing_model
